// file: logic/subtract_skip_swap_exec.sv
// Execution unit for skip-if-nonzero, subtract variants and nibble swap
`timescale 1ns/1ps

module subtract_skip_swap_exec
	import subtract_skip_swap_pkg::*;
(
	// Clock and reset
	input  wire logic                  clock,
	input  wire logic                  arst_n,
	// Instruction from the decoder
	input  wire logic                  opValid,
	input  wire logic [2:0]            opCode,
	input  wire logic [ADDR_W-1:0]     opAddr,
	input  wire logic [DATA_W-1:0]     opImm,
	output logic                       opReady,
	output logic                       opDone,
	output logic                       skipReq,
	// Data memory port
	output logic                       memRdEn,
	output logic [ADDR_W-1:0]          memAddr,
	input  wire logic [DATA_W-1:0]     memRdData,
	output logic                       memWrEn,
	output logic [DATA_W-1:0]          memWrData,
	// Accumulator and flags seen by the core
	output logic [DATA_W-1:0]          accumulator,
	output logic [FLAGS_W-1:0]         flags,
	// Register port
	input  wire logic [REG_ADDR_W-1:0] regAddr,
	input  wire logic [DATA_W-1:0]     regWrData,
	input  wire logic                  regWr,
	input  wire logic                  regRd,
	output logic [DATA_W-1:0]          regRdData
);

	// ***********************************************************
	// Subtract with all flags: returns {flags, difference}
	// ***********************************************************
	function automatic logic [FLAGS_W+DATA_W-1:0] sub_flags(
		input logic [DATA_W-1:0] a,
		input logic [DATA_W-1:0] b
	);
		logic [DATA_W:0]      full;
		logic [4:0]           low;
		logic [FLAGS_W-1:0]   f;
		full = {1'b0, a} - {1'b0, b};
		low  = {1'b0, a[3:0]} - {1'b0, b[3:0]};
		f = '0;
		f[FLAG_C]  = ~full[DATA_W];                                // see RULE7
		f[FLAG_AC] = ~low[4];                                      // see RULE10
		f[FLAG_Z]  = (full[DATA_W-1:0] == ZERO_BYTE);              // see RULE10
		f[FLAG_OV] = (a[7] != b[7]) && (full[7] != a[7]);          // see RULE10
		f[FLAG_SC] = ~(f[FLAG_OV] ^ full[7]);
		f[FLAG_CZ] = f[FLAG_Z];
		return {f, full[DATA_W-1:0]};
	endfunction

	// ***********************************************************
	// Reset release
	// ***********************************************************
	logic rstMeta_reg;
	logic rstN;

	// Two stages so release never lands near a clock edge
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			rstMeta_reg <= 1'b0;
			rstN        <= 1'b0;
		end else begin
			rstMeta_reg <= 1'b1;
			rstN        <= rstMeta_reg;
		end
	end

	// ***********************************************************
	// State
	// ***********************************************************
	state_t              state_reg;
	state_t              state_next;
	op_t                 op_reg;
	logic [ADDR_W-1:0]   addr_reg;
	logic [DATA_W-1:0]   imm_reg;
	logic [DATA_W-1:0]   acc_reg;
	logic [FLAGS_W-1:0]  flag_reg;
	logic [DATA_W-1:0]   opB;
	logic [DATA_W-1:0]   diffRes;
	logic [FLAGS_W-1:0]  flagsNew;
	logic                isSub;
	logic                skipTake;
	logic                execNow;
	logic                accSwWr;

	assign opReady  = (state_reg == ST_IDLE);
	assign memRdEn  = (state_reg == ST_READ);
	assign execNow  = (state_reg == ST_EXEC);
	assign memAddr  = addr_reg;
	assign accumulator = acc_reg;
	assign flags    = flag_reg;
	assign accSwWr  = regWr && (regAddr == REG_ACC);

	// Second operand: the instruction constant or the fetched byte
	assign opB = (op_reg == OP_SUB_IMM) ? imm_reg : memRdData;          // see RULE6
	assign {flagsNew, diffRes} = sub_flags(acc_reg, opB);
	assign isSub = (op_reg == OP_SUB_MEM) || (op_reg == OP_SUB_TO_MEM)
		|| (op_reg == OP_SUB_IMM);
	assign skipTake = (op_reg == OP_SKIP_NZ) && (memRdData != ZERO_BYTE); // see RULE2

	// ***********************************************************
	// Sequencer
	// ***********************************************************
	// Immediate work needs no memory read, so it goes straight to execute
	always_comb begin
		state_next = state_reg;
		case (state_reg)
			ST_IDLE: begin
				if (opValid) begin
					state_next = (op_t'(opCode) == OP_SUB_IMM) ? ST_EXEC : ST_READ;
				end
			end
			ST_READ: begin
				state_next = ST_EXEC;
			end
			ST_EXEC: begin
				state_next = skipTake ? ST_DUMMY : ST_IDLE;           // see RULE3
			end
			ST_DUMMY: begin
				state_next = ST_IDLE;
			end
			default: begin
				state_next = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge clock or negedge rstN) begin
		if (!rstN) begin
			state_reg <= ST_IDLE;
		end else begin
			state_reg <= state_next;
		end
	end

	// Latch the instruction when it is taken
	always_ff @(posedge clock or negedge rstN) begin
		if (!rstN) begin
			op_reg   <= OP_SKIP_NZ;
			addr_reg <= '0;
			imm_reg  <= '0;
		end else if (opValid && opReady) begin
			op_reg   <= op_t'(opCode);
			addr_reg <= opAddr;
			imm_reg  <= opImm;
		end
	end

	// Done and skip pulses; a taken skip holds done back one dummy cycle
	always_ff @(posedge clock or negedge rstN) begin
		if (!rstN) begin
			opDone  <= 1'b0;
			skipReq <= 1'b0;
		end else begin
			opDone  <= (execNow && !skipTake) || (state_reg == ST_DUMMY); // see RULE3
			skipReq <= execNow && skipTake;                              // see RULE2
		end
	end

	// ***********************************************************
	// Memory write-back
	// ***********************************************************
	// Unknown codes fall through with no write, so they act as no-ops
	always_ff @(posedge clock or negedge rstN) begin
		if (!rstN) begin
			memWrEn   <= 1'b0;
			memWrData <= '0;
		end else begin
			memWrEn <= 1'b0;
			if (execNow) begin
				case (op_reg)
					OP_SKIP_NZ: begin
						memWrEn   <= 1'b1;
						memWrData <= memRdData;                          // see RULE1
					end
					OP_SUB_TO_MEM: begin
						memWrEn   <= 1'b1;
						memWrData <= diffRes;                            // see RULE5
					end
					OP_SWAP: begin
						memWrEn   <= 1'b1;
						memWrData <= {memRdData[3:0], memRdData[7:4]};   // see RULE9
					end
					default: begin
						memWrEn <= 1'b0;
					end
				endcase
			end
		end
	end

	// ***********************************************************
	// Accumulator and flags
	// ***********************************************************
	// Instruction results win over a software write in the same cycle
	always_ff @(posedge clock or negedge rstN) begin
		if (!rstN) begin
			acc_reg <= ACC_RESET;
		end else if (execNow && (op_reg == OP_SUB_MEM || op_reg == OP_SUB_IMM)) begin
			acc_reg <= diffRes;                                      // see RULE4
		end else if (accSwWr) begin
			acc_reg <= regWrData;
		end
	end

	// Skip and swap leave the flags alone
	always_ff @(posedge clock or negedge rstN) begin
		if (!rstN) begin
			flag_reg <= FLAGS_RESET;
		end else if (execNow && isSub) begin
			flag_reg <= flagsNew;                                    // see RULE8
		end else if (regWr && regAddr == REG_STATUS) begin
			flag_reg <= regWrData[FLAGS_W-1:0];
		end
	end

	// ***********************************************************
	// Register read port
	// ***********************************************************
	// Unmapped offsets read as zero
	always_ff @(posedge clock or negedge rstN) begin
		if (!rstN) begin
			regRdData <= '0;
		end else if (regRd) begin
			if (regAddr == REG_ACC) begin
				regRdData <= acc_reg;
			end else if (regAddr == REG_STATUS) begin
				regRdData <= {2'h0, flag_reg};
			end else if (regAddr == REG_STATE) begin
				regRdData <= {6'h00, state_reg};
			end else begin
				regRdData <= '0;
			end
		end else begin
			regRdData <= '0;
		end
	end

	// ***********************************************************
	// Assertions
	// ***********************************************************
	logic lowNoBorrow;
	assign lowNoBorrow = (acc_reg[3:0] >= opB[3:0]);

	default clocking @(posedge clock); endclocking
	default disable iff (!rstN);

	property p_writeBack;
		execNow && op_reg == OP_SKIP_NZ |=>
			memWrEn && memWrData == $past(memRdData) && memAddr == $past(memAddr);
	endproperty
	a_writeBack: assert property (p_writeBack) else $error("Skip byte not written back"); // see RULE1

	property p_skipNonzero;
		execNow && op_reg == OP_SKIP_NZ && !regWr |=>
			skipReq == ($past(memRdData) != ZERO_BYTE) && $stable(flag_reg);
	endproperty
	a_skipNonzero: assert property (p_skipNonzero) else $error("Skip decision wrong"); // see RULE2

	property p_dummyCycle;
		skipReq |-> !opDone && state_reg == ST_DUMMY ##1 opDone && opReady;
	endproperty
	a_dummyCycle: assert property (p_dummyCycle) else $error("Skip lacks dummy cycle"); // see RULE3

	property p_subMem;
		execNow && op_reg == OP_SUB_MEM |=> acc_reg == $past(diffRes) && !memWrEn;
	endproperty
	a_subMem: assert property (p_subMem) else $error("Memory subtract wrong"); // see RULE4

	property p_subToMem;
		execNow && op_reg == OP_SUB_TO_MEM && !accSwWr |=>
			memWrEn && memWrData == $past(diffRes) && $stable(acc_reg);
	endproperty
	a_subToMem: assert property (p_subToMem) else $error("Subtract to memory wrong"); // see RULE5

	property p_subImm;
		execNow && op_reg == OP_SUB_IMM |=> acc_reg == 8'($past(acc_reg) - $past(imm_reg));
	endproperty
	a_subImm: assert property (p_subImm) else $error("Immediate subtract wrong"); // see RULE6

	property p_carry;
		execNow && isSub |=> flag_reg[FLAG_C] == ($past(acc_reg) >= $past(opB));
	endproperty
	a_carry: assert property (p_carry) else $error("Carry flag wrong"); // see RULE7

	property p_flagsAll;
		execNow && isSub |=> flag_reg[FLAG_Z] == ($past(diffRes) == ZERO_BYTE)
			&& flag_reg[FLAG_CZ] == flag_reg[FLAG_Z]
			&& flag_reg[FLAG_SC] == ~(flag_reg[FLAG_OV] ^ $past(diffRes[7]));
	endproperty
	a_flagsAll: assert property (p_flagsAll) else $error("Status flags wrong"); // see RULE8

	property p_swap;
		execNow && op_reg == OP_SWAP |=>
			memWrEn && {memWrData[3:0], memWrData[7:4]} == $past(memRdData);
	endproperty
	a_swap: assert property (p_swap) else $error("Nibble swap wrong"); // see RULE9

	property p_halfBorrow;
		execNow && isSub |=> flag_reg[FLAG_AC] == $past(lowNoBorrow);
	endproperty
	a_halfBorrow: assert property (p_halfBorrow) else $error("Half carry wrong"); // see RULE10

	c_skipTaken:  cover property (execNow && op_reg == OP_SKIP_NZ && skipTake);
	c_skipPassed: cover property (execNow && op_reg == OP_SKIP_NZ && !skipTake);
	c_borrow:     cover property (execNow && isSub && !flagsNew[FLAG_C]);
	c_swap:       cover property (execNow && op_reg == OP_SWAP);

endmodule

// file: logic/subtract_skip_swap_pkg.sv
// Constants, encodings and types for the subtract, skip and swap datapath
// How it works
// RULE1: Skip test writes the read byte back
// RULE2: Skip when byte nonzero; flags untouched
// RULE3: Taken skip adds one dummy cycle
// RULE4: Memory subtract: accumulator gets accumulator minus byte
// RULE5: Subtract to memory: byte gets difference
// RULE6: Immediate subtract: accumulator minus instruction constant
// RULE7: Carry cleared on borrow, else set
// RULE8: Every subtract updates all six flags
// RULE9: Swap exchanges byte nibbles in place
// RULE10: Eight-bit operands; zero, overflow, half borrow
package subtract_skip_swap_pkg;

	// ***********************************************************
	// Widths
	// ***********************************************************
	localparam int DATA_W     = 8;
	localparam int ADDR_W     = 8;
	localparam int REG_ADDR_W = 2;
	localparam int FLAGS_W    = 6;

	// ***********************************************************
	// Flag bit positions inside the status register
	// ***********************************************************
	localparam int FLAG_C  = 0;
	localparam int FLAG_AC = 1;
	localparam int FLAG_Z  = 2;
	localparam int FLAG_OV = 3;
	localparam int FLAG_SC = 4;
	localparam int FLAG_CZ = 5;

	// ***********************************************************
	// Register offsets and reset values
	// ***********************************************************
	localparam logic [REG_ADDR_W-1:0] REG_ACC    = 2'h0;
	localparam logic [REG_ADDR_W-1:0] REG_STATUS = 2'h1;
	localparam logic [REG_ADDR_W-1:0] REG_STATE  = 2'h2;
	localparam logic [DATA_W-1:0]     ACC_RESET   = 8'h00;
	localparam logic [FLAGS_W-1:0]    FLAGS_RESET = 6'h00;
	localparam logic [DATA_W-1:0]     ZERO_BYTE   = 8'h00;

	// ***********************************************************
	// Operation codes and sequencer states
	// ***********************************************************
	typedef enum logic [2:0] {
		OP_SKIP_NZ   = 3'h0,
		OP_SUB_MEM   = 3'h1,
		OP_SUB_TO_MEM = 3'h2,
		OP_SUB_IMM   = 3'h3,
		OP_SWAP      = 3'h4
	} op_t;

	typedef enum logic [1:0] {
		ST_IDLE  = 2'h0,
		ST_READ  = 2'h1,
		ST_EXEC  = 2'h2,
		ST_DUMMY = 2'h3
	} state_t;

endpackage

// file: tb/data_mem_model.sv
// Data memory model on the far side of the execution unit
`timescale 1ns/1ps

module data_mem_model
	import subtract_skip_swap_pkg::*;
(
	// Clock
	input  wire logic              clock,
	// Memory port
	input  wire logic              memRdEn,
	input  wire logic [ADDR_W-1:0] memAddr,
	output logic [DATA_W-1:0]      memRdData,
	input  wire logic              memWrEn,
	input  wire logic [DATA_W-1:0] memWrData
);
	logic [DATA_W-1:0] mem [256];

	// Seed contents so every address starts different
	initial begin
		for (int i = 0; i < 256; i++) begin
			mem[i] = i[7:0] ^ 8'h5a;
		end
	end

	// Read answers next cycle; idle data flips so stale bytes never pass
	always @(posedge clock) begin
		memRdData <= memRdEn ? mem[memAddr] : ~memRdData;
		if (memWrEn) begin
			mem[memAddr] <= memWrData;
		end
	end
endmodule

// file: tb/subtract_skip_swap_exec_tb.sv
// Self-checking bench for the subtract, skip and swap execution unit
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin bad_count++; \
	$display("[FAIL] %s exp %h got %h", nm, e, g); end end

module subtract_skip_swap_exec_tb
	import subtract_skip_swap_pkg::*;
;
	logic clock = 0, arst_n = 0, opValid = 0, regWr = 0, regRd = 0;
	logic [2:0] opCode = 3'h0;
	logic [7:0] opAddr = 8'h00, opImm = 8'h00, regWrData = 8'h00;
	logic [1:0] regAddr = 2'h0;
	logic opReady, opDone, skipReq, memRdEn, memWrEn;
	logic [7:0] memAddr, memRdData, memWrData, accumulator, regRdData;
	logic [5:0] flags, flagsExp;
	logic [7:0] accExp;
	int bad_count = 0, n_checks = 0, seed = 26;

	subtract_skip_swap_exec dut (.clock(clock), .arst_n(arst_n), .opValid(opValid),
		.opCode(opCode), .opAddr(opAddr), .opImm(opImm), .opReady(opReady),
		.opDone(opDone), .skipReq(skipReq), .memRdEn(memRdEn), .memAddr(memAddr),
		.memRdData(memRdData), .memWrEn(memWrEn), .memWrData(memWrData),
		.accumulator(accumulator), .flags(flags), .regAddr(regAddr),
		.regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData(regRdData));
	data_mem_model mem (.clock(clock), .memRdEn(memRdEn), .memAddr(memAddr),
		.memRdData(memRdData), .memWrEn(memWrEn), .memWrData(memWrData));

	// ***********************************************************
	// Expectation helpers
	// ***********************************************************
	// Flags of a minus b: {chained zero, signed carry, overflow, zero, half, carry}
	function automatic logic [5:0] flagsOf(input logic [7:0] a, input logic [7:0] b);
		logic [8:0] d;
		logic [4:0] h;
		logic ov;
		d = {1'b0, a} - {1'b0, b};
		h = {1'b0, a[3:0]} - {1'b0, b[3:0]};
		ov = (a[7] != b[7]) && (d[7] != a[7]);
		return {d[7:0] == 8'h00, ~(ov ^ d[7]), ov, d[7:0] == 8'h00, ~h[4], ~d[8]};
	endfunction

	task automatic regW(input logic [1:0] a, input logic [7:0] d);
		@(posedge clock);
		regWr <= 1'b1;
		regAddr <= a;
		regWrData <= d;
		@(posedge clock);
		regWr <= 1'b0;
	endtask

	// Read data only stand in the cycle after the strobe
	task automatic regR(input logic [1:0] a, input logic [7:0] e);
		@(posedge clock);
		regRd <= 1'b1;
		regAddr <= a;
		@(posedge clock);
		regRd <= 1'b0;
		#1;
		`CHK("regRdData", e, regRdData)
	endtask

	task automatic doOp(input logic [2:0] c, input logic [7:0] a, input logic [7:0] im);
		logic [7:0] b, r, memExp;
		logic wr, sk, wrExp;
		int n, lat;
		b = mem.mem[a];
		r = (c == 3'h3) ? accExp - im : accExp - b;
		wr = 0;
		sk = 0;
		n = 0;
		wrExp = (c == 3'h0) || (c == 3'h2) || (c == 3'h4);
		memExp = (c == 3'h2) ? r : (c == 3'h4) ? {b[3:0], b[7:4]} : b;
		// Edges counted after the take edge: read (none for immediate), execute, optional dummy
		lat = (c == 3'h3) ? 1 : (c == 3'h0 && b != 8'h00) ? 3 : 2;
		if (c inside {3'h1, 3'h2, 3'h3}) begin
			flagsExp = flagsOf(accExp, (c == 3'h3) ? im : b);
		end
		if (c == 3'h1 || c == 3'h3) begin
			accExp = r;
		end
		@(posedge clock);
		opValid <= 1'b1;
		opCode <= c;
		opAddr <= a;
		opImm <= im;
		@(posedge clock);
		opValid <= 1'b0;
		do begin
			@(posedge clock);
			#1;
			n++;
			wr |= (memWrEn === 1'b1);
			sk |= (skipReq === 1'b1);
		end while (opDone !== 1'b1 && n < 8);
		// The write pulse lands in memory one edge after it is driven
		@(posedge clock);
		#1;
		`CHK("latency", lat, n)
		`CHK("skipReq", (c == 3'h0 && b != 8'h00), sk)
		`CHK("memWrEn", wrExp, wr)
		`CHK("memory", memExp, mem.mem[a])
		`CHK("accumulator", accExp, accumulator)
		`CHK("carry", flagsExp[FLAG_C], flags[FLAG_C])
		`CHK("flags", flagsExp, flags)
	endtask

	// Preset accumulator and operand, then run one instruction
	task automatic corner(input logic [2:0] c, input logic [7:0] ac, input logic [7:0] m,
		input logic [7:0] im);
		regW(REG_ACC, ac);
		accExp = ac;
		mem.mem[8'h40] = m;
		doOp(c, 8'h40, im);
	endtask

	task automatic end_of_test();
		$display("checks %0d mismatches %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	// ***********************************************************
	// Clock, watchdog and main sequence
	// ***********************************************************
	initial begin
		forever #10 clock = ~clock;
	end

	// Generous bound: the sequence needs well under 2000 cycles
	initial begin
		#400000;
		bad_count++;
		end_of_test();
	end

	initial begin
		accExp = ACC_RESET;
		flagsExp = FLAGS_RESET;
		repeat (8) @(posedge clock);
		arst_n <= 1'b1;
		repeat (3) @(posedge clock);
		regR(REG_ACC, 8'h00);
		regR(REG_STATUS, 8'h00);
		regR(REG_STATE, 8'h00);
		regR(2'h3, 8'h00);
		regW(2'h3, 8'hff);
		regW(REG_STATUS, 8'hff);
		flagsExp = 6'h3f;
		regR(REG_STATUS, 8'h3f);
		corner(3'h0, 8'h11, 8'h00, 8'h00);
		corner(3'h0, 8'h11, 8'h01, 8'h00);
		corner(3'h1, 8'h05, 8'h05, 8'h00);
		corner(3'h1, 8'h00, 8'h01, 8'h00);
		corner(3'h2, 8'h80, 8'h01, 8'h00);
		corner(3'h3, 8'h10, 8'h77, 8'h01);
		corner(3'h3, 8'h7f, 8'h00, 8'hff);
		corner(3'h4, 8'h00, 8'ha5, 8'h00);
		for (int c = 5; c < 8; c++) begin
			corner(c[2:0], 8'h33, 8'h44, 8'h55);
		end
		regR(REG_STATUS, {2'h0, flagsExp});
		for (int i = 0; i < 60; i++) begin
			if (i % 7 == 0) begin
				corner($random(seed), $random(seed), $random(seed), $random(seed));
			end else begin
				doOp($random(seed), $random(seed), $random(seed));
			end
		end
		regR(REG_ACC, accExp);
		end_of_test();
	end
endmodule
